// File: test/bocd_datapath_props.sv
/*
 * bocd_datapath_props: timing checks on the data path ports.
 * Assumes it is bound to every bocd_datapath instance by the bind below.
 */
`timescale 1ns/1ps
`default_nettype none

module bocd_datapath_props
	import bocd_pkg::*;
#(
	parameter int QUARTER_LEN = QUARTER_CYCLES // core cycles per quarter
)
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [PADDR_W-1:0] program_address_o,
	input wire logic [DATA_W-1:0] io_bus_lines_o,
	input wire logic io_bus_lines_oe_o,
	input wire logic select_command_o,
	input wire logic write_command_o,
	input wire logic left_bank_select_n_o,
	input wire logic right_bank_select_n_o,
	input wire logic master_clock_o,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	logic [7:0] hi_q; // master clock high run
	logic [7:0] lo_q; // master clock low run
	logic [7:0] oe_q; // drive window run
	logic seen_q; // one cycle end passed

	// run lengths of each level
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			hi_q <= 8'h00;
			lo_q <= 8'h00;
			oe_q <= 8'h00;
			seen_q <= 1'b0;
		end
		else
		begin
			hi_q <= master_clock_o ? hi_q + 8'h01 : 8'h00;
			lo_q <= master_clock_o ? 8'h00 : lo_q + 8'h01;
			oe_q <= io_bus_lines_oe_o ? oe_q + 8'h01 : 8'h00;
			if ($fell(master_clock_o))
				seen_q <= 1'b1;
		end
	end

	AST_CMD_EXCL: assert property (!(select_command_o && write_command_o))
		else $error("select and write high together");
	AST_BANK_COMPL: assert property (left_bank_select_n_o != right_bank_select_n_o)
		else $error("bank selects not complementary");
	AST_MC_LEN: assert property ($fell(master_clock_o) |-> hi_q == 8'(QUARTER_LEN))
		else $error("master clock not one quarter long");
	AST_DRIVE_LEN: assert property ($fell(io_bus_lines_oe_o) |-> oe_q == 8'(2*QUARTER_LEN))
		else $error("drive window not two quarters");
	AST_DRIVE_Q3: assert property ($rose(master_clock_o) && io_bus_lines_oe_o |-> oe_q == 8'(QUARTER_LEN))
		else $error("drive did not start in quarter three");
	AST_CYCLE_LEN: assert property ($rose(master_clock_o) && seen_q |-> lo_q == 8'(3*QUARTER_LEN))
		else $error("first three quarters wrong length");
	AST_CMD_DRIVEN: assert property (select_command_o || write_command_o |-> io_bus_lines_oe_o)
		else $error("command without bus drive");
	AST_ADDR_AT_END: assert property (!$stable(program_address_o) |-> $fell(master_clock_o))
		else $error("address moved inside a cycle");
	AST_DATA_STEADY: assert property (io_bus_lines_oe_o && $past(io_bus_lines_oe_o) && $past(io_bus_lines_oe_o, 2)
		|-> $stable(io_bus_lines_o))
		else $error("bus data moved while driven");
	AST_BANK_Q4: assert property (master_clock_o |-> $stable(left_bank_select_n_o))
		else $error("bank changed in quarter four");
	AST_AVS_WAIT: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("register access not one wait state");

endmodule : bocd_datapath_props

bind bocd_datapath bocd_datapath_props #(.QUARTER_LEN(QUARTER_LEN)) u_props (
	.ref_clk_i(ref_clk_i),
	.rst_n_i(rst_n_i),
	.program_address_o(program_address_o),
	.io_bus_lines_o(io_bus_lines_o),
	.io_bus_lines_oe_o(io_bus_lines_oe_o),
	.select_command_o(select_command_o),
	.write_command_o(write_command_o),
	.left_bank_select_n_o(left_bank_select_n_o),
	.right_bank_select_n_o(right_bank_select_n_o),
	.master_clock_o(master_clock_o),
	.avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i),
	.avs_waitrequest_o(avs_waitrequest_o)
);

`default_nettype wire

// File: test/bocd_periph_model.sv
/*
 * bocd_periph_model: program storage and two banks of bus ports.
 * Assumes the bench loads rom before reset ends.
 */
`timescale 1ns/1ps
`default_nettype none

module bocd_periph_model
	import bocd_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic [PADDR_W-1:0] program_address_i,
	output logic [INSTR_W-1:0] instruction_inputs_o,
	input wire logic [DATA_W-1:0] dev_bus_i,
	input wire logic dev_oe_i,
	input wire logic select_command_i,
	input wire logic write_command_i,
	input wire logic left_bank_select_n_i,
	input wire logic master_clock_i,
	output logic [DATA_W-1:0] bus_wire_o
);
	logic [INSTR_W-1:0] rom [0:63]; // program words
	logic [DATA_W-1:0] mem [0:1][0:255]; // port contents per bank
	logic [DATA_W-1:0] port_addr [0:1]; // last address per bank
	logic [16:0] log_q [0:31]; // writes: bank, address, data
	int n_log; // writes seen
	logic mc_q; // master clock one cycle ago
	logic bank; // high while right bank enabled
	assign bank = left_bank_select_n_i;
	// word of current address stands all cycle
	assign instruction_inputs_o = rom[program_address_i[5:0]];
	// device drive wins, else the addressed port answers
	assign bus_wire_o = dev_oe_i ? dev_bus_i : mem[bank][port_addr[bank]];

	// empty ports and program
	initial
	begin
		n_log = 0;
		port_addr[0] = 8'h00;
		port_addr[1] = 8'h00;
		for (int i = 0; i < 256; i++)
		begin
			mem[0][i] = 8'h00;
			mem[1][i] = 8'h00;
		end
		for (int i = 0; i < 64; i++)
			rom[i] = 16'h0000;
	end

	// take address or data as master clock rises
	always @(posedge ref_clk_i)
	begin
		mc_q <= master_clock_i;
		if (master_clock_i && !mc_q && select_command_i)
			port_addr[bank] <= bus_wire_o;
		if (master_clock_i && !mc_q && write_command_i)
		begin
			mem[bank][port_addr[bank]] <= bus_wire_o;
			log_q[n_log[4:0]] <= {bank, port_addr[bank], bus_wire_o};
			n_log <= n_log + 1;
		end
	end

endmodule : bocd_periph_model

`default_nettype wire

// File: test/tb_top.sv
/*
 * tb_top: runs a program through the data path and checks port writes and registers.
 * Assumes the peripheral model and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import bocd_pkg::*;
;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [PADDR_W-1:0] program_address_o;
	logic [INSTR_W-1:0] instruction_inputs_i;
	logic [DATA_W-1:0] io_bus_lines_i, io_bus_lines_o;
	logic io_bus_lines_oe_o, select_command_o, write_command_o;
	logic left_bank_select_n_o, right_bank_select_n_o, master_clock_o;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hF; // lane 0 gates control writes
	logic [31:0] avs_readdata_o, rd;
	logic avs_waitrequest_o;
	logic [1:0] qtr; // quarter seen once run is cleared
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	// literals, alu classes, address and port moves, jump to self
	logic [15:0] prog [0:22] = '{16'hC15A, 16'hC00F, 16'h0182, 16'h2203, 16'h4204, 16'h6205, 16'h0107,
		16'h050F, 16'h0310, 16'h0471, 16'h1006, 16'h1490, 16'h1098, 16'h0218, 16'h0318, 16'h0418,
		16'h0518, 16'h0618, 16'hC0FF, 16'h2501, 16'h0118, 16'hC03C, 16'hE016};
	// expected writes: bank, port address, data
	logic [16:0] exp_log [0:9] = '{17'h05AB4, 17'h05ABA, 17'h05ABB, 17'h1AA0B, 17'h1AAA5,
		17'h1AAB4, 17'h1AA05, 17'h1AAAA, 17'h1AABA, 17'h1AAA9};

	// core clock
	always #5 ref_clk_i = ~ref_clk_i;

	bocd_datapath #(.QUARTER_LEN(7)) u_dut (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.program_address_o(program_address_o),
		.instruction_inputs_i(instruction_inputs_i),
		.io_bus_lines_i(io_bus_lines_i),
		.io_bus_lines_o(io_bus_lines_o),
		.io_bus_lines_oe_o(io_bus_lines_oe_o),
		.select_command_o(select_command_o),
		.write_command_o(write_command_o),
		.left_bank_select_n_o(left_bank_select_n_o),
		.right_bank_select_n_o(right_bank_select_n_o),
		.master_clock_o(master_clock_o),
		.avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o)
	);

	bocd_periph_model u_part (
		.ref_clk_i(ref_clk_i),
		.program_address_i(program_address_o),
		.instruction_inputs_o(instruction_inputs_i),
		.dev_bus_i(io_bus_lines_o),
		.dev_oe_i(io_bus_lines_oe_o),
		.select_command_i(select_command_o),
		.write_command_i(write_command_o),
		.left_bank_select_n_i(left_bank_select_n_o),
		.master_clock_i(master_clock_o),
		.bus_wire_o(io_bus_lines_i)
	);

	// counts, verdict and end of run
	task final_report;
		$display("fails %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	// one compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// one register access, held until waitrequest is seen low
	task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= wd;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		// request stands until the rising edge that sees waitrequest low
		do
		begin
			@(posedge ref_clk_i);
			n++;
		end
		while (avs_waitrequest_o !== 1'b0 && n < 50);
		d = avs_readdata_o;
		chk({31'h0, avs_waitrequest_o}, 32'h0, "no answer");
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask : avs

	// hang guard
	always @(posedge ref_clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_fail = n_fail + 1;
			final_report();
		end
	end

	// main sequence
	initial
	begin
		#1;
		for (int i = 0; i < 23; i++)
			u_part.rom[i] = prog[i];
		repeat (3) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		avs(1'b0, REG_CTRL_ADDR, 32'h0, rd);
		chk(rd, {31'h0, CTRL_RUN_RESET}, "run reset value");
		avs(1'b0, 4'hC, 32'h0, rd);
		chk(rd, 32'h0, "unmapped read");
		$display("test registers done");
		repeat (28 * 24) @(posedge ref_clk_i);
		chk(32'(u_part.n_log), 32'd10, "write count");
		for (int i = 0; i < 10; i++)
			chk({15'h0, u_part.log_q[i]}, {15'h0, exp_log[i]}, "port write");
		$display("test program done");
		avs(1'b0, REG_STATUS_ADDR, 32'h0, rd);
		chk({19'h0, rd[12:0]}, 32'h16, "jump target");
		chk({31'h0, rd[STATUS_CARRY_BIT]}, 32'h1, "carry");
		avs(1'b0, REG_DATA_ADDR, 32'h0, rd);
		chk({24'h0, rd[7:0]}, 32'h3C, "literal to aux");
		$display("test status done");
		avs_byteenable_i <= 4'h0;
		avs(1'b1, REG_CTRL_ADDR, 32'h0, rd);
		avs_byteenable_i <= 4'hF;
		avs(1'b0, REG_CTRL_ADDR, 32'h0, rd);
		chk(rd, {31'h0, CTRL_RUN_RESET}, "masked write ignored");
		avs(1'b1, REG_CTRL_ADDR, 32'h0, rd);
		avs(1'b0, REG_CTRL_ADDR, 32'h0, rd);
		chk(rd, 32'h0, "run cleared");
		avs(1'b0, REG_STATUS_ADDR, 32'h0, rd);
		qtr = rd[STATUS_QTR_LSB +: 2];
		repeat (40) @(posedge ref_clk_i);
		avs(1'b0, REG_STATUS_ADDR, 32'h0, rd);
		chk({30'h0, rd[STATUS_QTR_LSB +: 2]}, {30'h0, qtr}, "stalled quarter");
		$display("test stall done");
		final_report();
	end

endmodule : tb_top

`default_nettype wire

// File: verilog/bocd_datapath.sv
/*
 * bocd_datapath: working registers, ALU with carry, rotate/mask/shift/merge logic,
 * I/O latches and four-quarter instruction sequencing of the bit-oriented controller.
 * Assumes program storage answers on instruction_inputs_i within the first quarter,
 * peripherals drive io_bus_lines_i in the first half, and the bench resolves the bus wire.
 */
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module bocd_datapath
	import bocd_pkg::*;
#(
	parameter int QUARTER_LEN = QUARTER_CYCLES // core cycles per quarter
)
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// program storage side
	output logic [PADDR_W-1:0] program_address_o,
	input wire logic [INSTR_W-1:0] instruction_inputs_i,
	// io bus, three signals for the two-way pins
	input wire logic [DATA_W-1:0] io_bus_lines_i,
	output logic [DATA_W-1:0] io_bus_lines_o,
	output logic io_bus_lines_oe_o,
	output logic select_command_o,
	output logic write_command_o,
	output logic left_bank_select_n_o,
	output logic right_bank_select_n_o,
	output logic master_clock_o,
	// avalon-mm register slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);

	// end-around right rotate
	function automatic logic [DATA_W-1:0] rotr(input logic [DATA_W-1:0] v, input logic [2:0] n);
		logic [2*DATA_W-1:0] w;
		w = {v, v} >> n;
		return w[DATA_W-1:0];
	endfunction : rotr

	// low-end mask of a field length, zero meaning all eight bits
	function automatic logic [DATA_W-1:0] len_mask(input logic [2:0] l);
		logic [DATA_W-1:0] m;
		m = (l == 3'h0) ? {DATA_W{1'b1}} : ~({DATA_W{1'b1}} << l);
		return m;
	endfunction : len_mask

	// working register index of an operand code
	function automatic logic [2:0] wreg_idx(input logic [4:0] c);
		logic [2:0] i;
		i = (c == CODE_R11) ? WREG_R11_IDX : c[2:0];
		return i;
	endfunction : wreg_idx

	// pin synchronisers, two flops each
	logic [INSTR_W-1:0] instr_meta_q; // first stage, read only by the second
	logic [INSTR_W-1:0] instr_sync_q;
	logic [DATA_W-1:0] bus_meta_q; // first stage, read only by the second
	logic [DATA_W-1:0] bus_sync_q;

	// sequencer
	bocd_quarter_type qtr_q; // current quarter
	logic [7:0] qcnt_q; // cycles within quarter
	logic run_q; // software run enable
	logic qtr_end; // last cycle of a quarter
	logic cyc_end; // last cycle of an instruction cycle
	logic q3_first; // first cycle of quarter three

	// architectural state
	logic [DATA_W-1:0] wreg_q [NUM_WREGS]; // aux, r1-r6, r11
	logic carry_q; // overflow register
	bocd_instr_type instr_q; // instruction register
	logic [DATA_W-1:0] io_latch_q; // bus input latches
	logic [DATA_W-1:0] io_out_q; // output data flop
	logic [PADDR_W-1:0] addr_q; // address of current instruction
	logic [PADDR_W-1:0] ret_q; // next sequential address
	logic indexed_q; // current instruction came from execute_indexed
	logic left_bank_q; // left bank is the active one
	logic ack_q; // bus slave answer phase
	logic [31:0] rdata_q; // registered read data

	// two-flop synchronisers for every pin input
	always_ff @(posedge ref_clk_i)
	begin
		instr_meta_q <= instruction_inputs_i;
		instr_sync_q <= instr_meta_q;
		bus_meta_q <= io_bus_lines_i;
		bus_sync_q <= bus_meta_q;
	end

	// quarter timing enables
	assign qtr_end = run_q && (qcnt_q == 8'(QUARTER_LEN - 1));
	assign cyc_end = qtr_end && (qtr_q == QTR_4);
	assign q3_first = (qtr_q == QTR_3) && (qcnt_q == 8'h00);

	// quarter counter and quarter state machine
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			qcnt_q <= 8'h00;
			qtr_q <= QTR_1;
		end
		else if (qtr_end)
		begin
			qcnt_q <= 8'h00;
			unique case (qtr_q)
				QTR_1: qtr_q <= QTR_2;
				QTR_2: qtr_q <= QTR_3;
				QTR_3: qtr_q <= QTR_4;
				QTR_4: qtr_q <= QTR_1;
			endcase
		end
		else if (run_q)
		begin
			qcnt_q <= qcnt_q + 8'h01;
		end
	end

	// operand decode, continuous selection
	wire bocd_op_type op = instr_q.op;
	wire is_lit = (op == OP_TRANSMIT_LITERAL);
	wire is_alu = (op == OP_MOVE) || (op == OP_ADD) || (op == OP_AND) || (op == OP_XOR);
	wire src_io = !is_lit && instr_q.src[4]; // source is a peripheral
	wire src_right = instr_q.src[3]; // source bank
	wire [4:0] dcode = is_lit ? instr_q.src : instr_q.dst; // literal puts destination in source field
	wire dst_io = (is_alu || is_lit) && dcode[4]; // destination is a peripheral
	wire dst_right = dcode[3]; // destination bank
	wire dst_addr = (is_alu || is_lit) && ((dcode == CODE_ADDR_LEFT) || (dcode == CODE_ADDR_RIGHT));
	wire dst_reg = (is_alu || is_lit) && !dcode[4] && !dst_addr && (dcode != CODE_CARRY);
	wire [2:0] field_len = is_lit ? instr_q.rl : (src_io || dst_io) ? instr_q.rl : 3'h0;

	// source fetch and rotate: register by rl unless the destination is a peripheral, peripheral by low source digit
	wire [DATA_W-1:0] src_raw = src_io ? io_latch_q :
		(instr_q.src == CODE_CARRY) ? DATA_W'(carry_q) : wreg_q[wreg_idx(instr_q.src)];
	wire [2:0] rot_amt = src_io ? instr_q.src[2:0] : (dst_io ? 3'h0 : instr_q.rl);
	wire [DATA_W-1:0] src_rot = rotr(src_raw, rot_amt);
	// masked peripheral input, zeros outside the field
	wire [DATA_W-1:0] operand = src_io ? (src_rot & len_mask(instr_q.rl)) : src_rot;

	// alu against the implicit operand register
	wire [DATA_W:0] sum = {1'b0, operand} + {1'b0, wreg_q[0]};
	logic [DATA_W-1:0] alu_out;
	always_comb
	begin
		unique case (op)
			OP_ADD: alu_out = sum[DATA_W-1:0];
			OP_AND: alu_out = operand & wreg_q[0];
			OP_XOR: alu_out = operand ^ wreg_q[0];
			OP_TRANSMIT_LITERAL: alu_out = dst_io ? DATA_W'(instr_q.dst) : {instr_q.rl, instr_q.dst};
			default: alu_out = operand; // move and control classes
		endcase
	end

	// output shift and merge for a peripheral destination
	wire [2:0] shift_amt = dst_io ? dcode[2:0] : 3'h0;
	wire [DATA_W-1:0] field_mask = len_mask(dst_io ? field_len : 3'h0) << shift_amt;
	wire [DATA_W-1:0] field = (alu_out << shift_amt) & field_mask;
	wire opposite = src_io && dst_io && (src_right != dst_right);
	// merge keeps untouched bits; opposite banks write all eight
	wire [DATA_W-1:0] merged = opposite ? field : ((io_latch_q & ~field_mask) | field);
	wire [DATA_W-1:0] out_data = dst_addr ? alu_out : merged;

	// branch targets
	wire [7:0] lit = src_io ? {3'h0, instr_q.dst} : {instr_q.rl, instr_q.dst};
	wire [PADDR_W-1:0] page8 = {addr_q[PADDR_W-1:8], 8'h00};
	wire [PADDR_W-1:0] page5 = {addr_q[PADDR_W-1:5], 5'h00};
	wire [7:0] xsum = lit + operand;
	wire [PADDR_W-1:0] br_tgt = src_io ? (page5 | PADDR_W'(lit[4:0])) : (page8 | PADDR_W'(lit));
	wire [PADDR_W-1:0] idx_tgt = src_io ? (page5 | PADDR_W'(xsum[4:0])) : (page8 | PADDR_W'(xsum));
	wire taken = (op == OP_JUMP_UNCONDITIONAL) || ((op == OP_BRANCH_IF_NONZERO) && (operand != '0));
	wire [PADDR_W-1:0] jump_tgt = (op == OP_JUMP_UNCONDITIONAL) ? {instr_q.src, instr_q.rl, instr_q.dst} : br_tgt;

	// output phase qualifiers
	wire out_phase = (qtr_q == QTR_3) || (qtr_q == QTR_4);
	bocd_bus_ctl_type bus_ctl;
	assign bus_ctl.select_command = out_phase && dst_addr;
	assign bus_ctl.write_command = out_phase && dst_io && !dst_addr;

	// instruction register, captured end of quarter one
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			instr_q <= '0;
		end
		else if (qtr_end && (qtr_q == QTR_1))
		begin
			instr_q <= instr_sync_q;
		end
	end

	// bus input latches: transparent through quarters one and two
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			io_latch_q <= '0;
		end
		else if ((qtr_q == QTR_1) || (qtr_q == QTR_2))
		begin
			io_latch_q <= bus_sync_q;
		end
	end

	// output data flop, loaded at the start of quarter three
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			io_out_q <= '0;
		end
		else if (q3_first)
		begin
			io_out_q <= out_data;
		end
	end

	// working registers, one generate entry each, written at cycle end
	genvar gi;
	generate
		for (gi = 0; gi < NUM_WREGS; gi++)
		begin : g_wreg
			always_ff @(posedge ref_clk_i)
			begin
				if (!rst_n_i)
				begin
					wreg_q[gi] <= '0;
				end
				else if (cyc_end && dst_reg && (wreg_idx(dcode) == 3'(gi)))
				begin
					wreg_q[gi] <= alu_out;
				end
			end
		end
	endgenerate

	// overflow register follows the add carry
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			carry_q <= 1'b0;
		end
		else if (cyc_end && (op == OP_ADD))
		begin
			carry_q <= sum[DATA_W];
		end
	end

	// program address sequencing
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			addr_q <= '0;
			ret_q <= PADDR_W'(1);
			indexed_q <= 1'b0;
		end
		else if (cyc_end)
		begin
			if (op == OP_EXECUTE_INDEXED)
			begin
				// fetch one remote instruction, then resume at ret_q
				addr_q <= idx_tgt;
				indexed_q <= 1'b1;
			end
			else if (taken)
			begin
				addr_q <= jump_tgt;
				ret_q <= jump_tgt + PADDR_W'(1);
				indexed_q <= 1'b0;
			end
			else
			begin
				addr_q <= ret_q;
				ret_q <= ret_q + PADDR_W'(1);
				indexed_q <= 1'b0;
			end
		end
	end

	// bank select: source bank in input phase, destination bank in output phase
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			left_bank_q <= 1'b1;
		end
		else if (qtr_end && (qtr_q == QTR_1) && instr_sync_q[12] && (instr_sync_q[15:13] != OP_TRANSMIT_LITERAL))
		begin
			left_bank_q <= !instr_sync_q[11];
		end
		else if (qtr_end && (qtr_q == QTR_1) && !instr_sync_q[12] && instr_sync_q[4])
		begin
			left_bank_q <= !instr_sync_q[3]; // register source: latch destination bank
		end
		else if (qtr_end && (qtr_q == QTR_2) && (dst_io || dst_addr))
		begin
			left_bank_q <= !dst_right;
		end
	end

	// pin outputs
	assign program_address_o = addr_q;
	assign io_bus_lines_o = io_out_q;
	assign io_bus_lines_oe_o = out_phase && (dst_io || dst_addr);
	assign select_command_o = bus_ctl.select_command;
	assign write_command_o = bus_ctl.write_command;
	assign left_bank_select_n_o = !left_bank_q;
	assign right_bank_select_n_o = left_bank_q;
	assign master_clock_o = (qtr_q == QTR_4);

	// avalon slave: one wait state, then answer
	wire req = avs_read_i || avs_write_i;
	wire hit_ctrl = (avs_address_i == REG_CTRL_ADDR);
	wire hit_status = (avs_address_i == REG_STATUS_ADDR);
	wire hit_data = (avs_address_i == REG_DATA_ADDR);
	wire [31:0] status_word = (32'(indexed_q) << STATUS_INDEXED_BIT) | (32'(carry_q) << STATUS_CARRY_BIT)
		| (32'(qtr_q) << STATUS_QTR_LSB) | 32'(addr_q);
	wire [31:0] data_word = (32'(io_latch_q) << DATA_LATCH_LSB) | 32'(wreg_q[0]);
	wire [31:0] rd_mux = hit_ctrl ? 32'(run_q) : hit_status ? status_word : hit_data ? data_word : 32'h0000_0000;

	assign avs_waitrequest_o = req && !ack_q;
	assign avs_readdata_o = rdata_q;

	// answer flop and read data capture
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			ack_q <= 1'b0;
			rdata_q <= '0;
		end
		else
		begin
			ack_q <= req && !ack_q;
			if (avs_read_i && !ack_q)
			begin
				rdata_q <= rd_mux; // unmapped reads as zero
			end
		end
	end

	// control register: run enable stalls sequencing
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			run_q <= CTRL_RUN_RESET;
		end
		else if (avs_write_i && ack_q && hit_ctrl && avs_byteenable_i[0])
		begin
			run_q <= avs_writedata_i[CTRL_RUN_BIT];
		end
	end

endmodule : bocd_datapath

`default_nettype wire

// File: verilog/bocd_pkg.sv
/*
 * bocd_pkg: shared constants and types for the bit-oriented controller data path.
 * Assumes a single 100 MHz core clock and an Avalon-MM register slave with byte addresses.
 */
`default_nettype none

package bocd_pkg;

	// core clock period and quarter-cycle timing, in picoseconds
	localparam int CLK_PERIOD_PS = 10000;
	localparam int QUARTER_MIN_PS = 62500; // 62.5 ns least quarter
	// least time rounds up to whole core cycles
	localparam int QUARTER_CYCLES = (QUARTER_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// data and instruction widths
	localparam int DATA_W = 8;
	localparam int INSTR_W = 16;
	localparam int PADDR_W = 13;
	localparam int NUM_WREGS = 8;

	// instruction classes held in the top three bits
	typedef enum logic [2:0] {
		OP_MOVE = 3'h0,
		OP_ADD = 3'h1,
		OP_AND = 3'h2,
		OP_XOR = 3'h3,
		OP_EXECUTE_INDEXED = 3'h4,
		OP_BRANCH_IF_NONZERO = 3'h5,
		OP_TRANSMIT_LITERAL = 3'h6,
		OP_JUMP_UNCONDITIONAL = 3'h7
	} bocd_op_type;

	// decoded instruction word: class, source, rotate/length, destination
	typedef struct packed {
		bocd_op_type op;
		logic [4:0] src;
		logic [2:0] rl;
		logic [4:0] dst;
	} bocd_instr_type;

	// quarters of the instruction cycle
	typedef enum logic [1:0] {
		QTR_1 = 2'h0,
		QTR_2 = 2'h1,
		QTR_3 = 2'h2,
		QTR_4 = 2'h3
	} bocd_quarter_type;

	// bus use qualifiers driven in the output phase
	typedef struct packed {
		logic select_command;
		logic write_command;
	} bocd_bus_ctl_type;

	// operand codes
	localparam logic [4:0] CODE_AUX = 5'h00;
	localparam logic [4:0] CODE_ADDR_LEFT = 5'h07;
	localparam logic [4:0] CODE_CARRY = 5'h08;
	localparam logic [4:0] CODE_R11 = 5'h09;
	localparam logic [4:0] CODE_ADDR_RIGHT = 5'h0F;
	localparam logic [2:0] WREG_R11_IDX = 3'h7;

	// register map, byte addresses
	localparam logic [3:0] REG_CTRL_ADDR = 4'h0;
	localparam logic [3:0] REG_STATUS_ADDR = 4'h4;
	localparam logic [3:0] REG_DATA_ADDR = 4'h8;
	localparam int CTRL_RUN_BIT = 0;
	localparam logic CTRL_RUN_RESET = 1'h1;
	localparam int STATUS_QTR_LSB = 16;
	localparam int STATUS_CARRY_BIT = 20;
	localparam int STATUS_INDEXED_BIT = 21;
	localparam int DATA_LATCH_LSB = 8;

endpackage : bocd_pkg

`default_nettype wire
